/* hw/ccc_pkg.sv */
`default_nettype none
package ccc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [31:0] IDX_CHANNEL_MODE_LOW  = 32'hFFFFF204;
  localparam logic [31:0] IDX_CHANNEL_MODE_HIGH = 32'hFFFFF206;
  localparam logic [31:0] IDX_OUTPUT_CTRL_LOW   = 32'hFFFFF208;
  localparam logic [31:0] IDX_OUTPUT_CTRL_HIGH  = 32'hFFFFF20A;
  localparam logic [31:0] IDX_TIMER_STATUS      = 32'hFFFFF20C;
  localparam logic [31:0] IDX_UNIT_CTRL         = 32'hFFFFF210;
  localparam logic [31:0] IDX_IRQ_STATUS        = 32'hFFFFF212;
  localparam logic [31:0] IDX_IRQ_MASK          = 32'hFFFFF214;
  localparam logic [31:0] IDX_VALUE_BASE        = 32'hFFFFF220;

  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  OUTCTL_RESET   = 8'h44;
  localparam logic [7:0]  OUTCTL_WMASK   = 8'hEE;
  localparam logic [7:0]  UNIT_RESET     = 8'h00;
  localparam logic [7:0]  UNIT_WMASK     = 8'h8F;
  localparam logic [5:0]  IRQ_RESET      = 6'h00;
  localparam logic [15:0] VALUE_RESET    = 16'h0000;
  localparam logic [3:0]  TIMER_OUT_RESET = 4'h0;

  // Unit control bit positions
  localparam int UNIT_EN_A    = 0;
  localparam int UNIT_EN_B    = 1;
  localparam int UNIT_CAPCMP0 = 2;
  localparam int UNIT_CAPCMP5 = 3;
  localparam int UNIT_POWER   = 7;
  // Output control field layout, four bits per channel
  localparam int OUT_CAPCMP = 1;
  localparam int OUT_ALV    = 2;
  localparam int OUT_GATE   = 3;
  localparam int OUT_FIELD  = 4;
  localparam int SEL_FIRST  = 4;

  localparam logic [3:0]  START_CYCLES = 4'h8;
  localparam logic [3:0]  STOP_CYCLES  = 4'h2;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } ccc_edge_t;

  typedef enum logic [1:0] {
    CNT_IDLE  = 2'b00,
    CNT_START = 2'b01,
    CNT_RUN   = 2'b11,
    CNT_STOP  = 2'b10
  } ccc_cnt_state_t;

  function automatic logic [31:0] byteAddr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction

  function automatic logic [31:0] valueAddr(input int n);
    return byteAddr(IDX_VALUE_BASE + {n[30:0], 1'b0});
  endfunction
endpackage
`default_nettype wire

/* hw/ccc_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module ccc_counter
  import ccc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  output var  logic [15:0] count,
  output var  logic        running,
  output var  logic        stepped,
  output var  logic        overflow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  ccc_cnt_state_t state;
  logic [3:0]     delay;

  // Start and stop both pass through a settling delay
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= CNT_IDLE;
      delay <= 4'h0;
    end else begin
      unique case (state)
        CNT_IDLE: if (enable) begin
          state <= CNT_START;
          delay <= START_CYCLES - 4'h1;
        end
        CNT_START: if (!enable) begin
          state <= CNT_IDLE;
        end else if (delay == 4'h0) begin
          state <= CNT_RUN;
        end else begin
          delay <= delay - 4'h1;
        end
        CNT_RUN: if (!enable) begin
          state <= CNT_STOP;
          delay <= STOP_CYCLES - 4'h1;
        end
        CNT_STOP: if (delay == 4'h0) begin
          state <= CNT_IDLE;
        end else begin
          delay <= delay - 4'h1;
        end
      endcase
    end
  end

  assign running = (state == CNT_RUN) || (state == CNT_STOP);

  // Counts only in RUN; the value is held when stopped
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count    <= 16'h0000;
      stepped  <= 1'b0;
      overflow <= 1'b0;
    end else begin
      stepped  <= (state == CNT_RUN);
      overflow <= (state == CNT_RUN) && (count == COUNT_MAX);
      if (state == CNT_RUN) begin
        count <= count + 16'h0001;
      end
    end
  end

  a_stop_delay: assert property ($fell(enable) && state == CNT_RUN |=> running [*2]) // [RL16]
    else $error("counter stopped in under two cycles");
  a_start_delay: assert property ($rose(enable) && state == CNT_IDLE |=> !running [*8]) // [RL16]
    else $error("counter started in under eight cycles");
endmodule
`default_nettype wire

/* hw/ccc_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module ccc_edge_detect
  import ccc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       pin,
  input  wire logic [1:0] select,
  output var  logic       hit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  logic syncA;
  logic syncB;
  logic syncC;
  logic level;
  logic agree;
  logic rise;
  logic fall;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
      level <= 1'b0;
    end else begin
      syncA <= pin;
      syncB <= syncA;
      syncC <= syncB;
      if (agree) begin
        level <= syncC; // [RL17]
      end
    end
  end

  always_comb begin
    agree = (syncB == syncC);
    rise  = agree && syncC && !level;
    fall  = agree && !syncC && level;
    unique case (ccc_edge_t'(select)) // [RL2]
      EDGE_FALL: hit = fall;
      EDGE_RISE: hit = rise;
      EDGE_NONE: hit = 1'b0;
      EDGE_BOTH: hit = rise || fall;
    endcase
  end

  a_edge_once: assert property (hit |=> !hit) // [RL17]
    else $error("one edge gave two hits");
  a_edge_none: assert property (select == EDGE_NONE |-> !hit) // [RL2]
    else $error("edge hit while detection disabled");
endmodule
`default_nettype wire

/* hw/ccc_channel_unit.sv */
// Summary of operation
// [RL1] Counter-select bit ties channel to counter a/b
// [RL2] Two-bit field picks capture edge per input
// [RL3] Software leaves mode registers alone while powered
// [RL4] Mode registers read and write as bytes
// [RL5] Gate off holds output at inactive level
// [RL6] Active-level bit sets output polarity
// [RL7] Stop counter, see running clear, then write
// [RL8] No active-level writes while powered and enabled
// [RL9] Capture edge copies counter, raises channel interrupt
// [RL10] Compare match raises interrupt, drives pulse output
// [RL11] No capture/compare select writes while powered
// [RL12] Overflow flags follow assigned counter overflows
// [RL13] Overflow flag updates after value register read
// [RL14] Top status bits show counters running
// [RL15] Status register is read only
// [RL16] Counter stop takes two cycles, start eight
// [RL17] Capture inputs synchronised, one hit per edge
// [RL18] Reserved output control bits read zero
`timescale 1ns/100ps
`default_nettype none
module ccc_channel_unit
  import ccc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [5:0]  captureInput,
  output var  logic [3:0]  timerOutput,
  output var  logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [7:0]  modeLow;
  logic [7:0]  modeHigh;
  logic [7:0]  outCtlLow;
  logic [7:0]  outCtlHigh;
  logic [7:0]  unitCtrl;
  logic [5:0]  irqStatus;
  logic [5:0]  irqMask;
  logic [5:0]  pendOvf;
  logic [5:0]  ovfFlag;
  logic [3:0]  pwmPhase;
  logic [15:0] valueReg [6];

  logic        dataWrite;
  logic [31:0] dataAddr;
  logic        accept;
  logic        readAccept;
  logic [31:0] rdValue;

  logic [15:0] countA;
  logic [15:0] countB;
  logic        runA;
  logic        runB;
  logic        stepA;
  logic        stepB;
  logic        ovfA;
  logic        ovfB;

  logic [15:0] chCount [6];
  logic [5:0]  chOvf;
  logic [5:0]  chStep;
  logic [5:0]  chEn;
  logic [5:0]  edgeHit;
  logic [5:0]  capHit;
  logic [5:0]  cmpHit;
  logic [5:0]  valueRead;
  logic [5:0]  irqClear;
  logic [15:0] outCtl;
  logic [11:0] edgeSel;

  assign outCtl  = {outCtlHigh, outCtlLow};
  assign edgeSel = {modeHigh[3:0], modeLow}; // [RL2]

  function automatic logic selB(input int n);
    if (n == 0) begin
      return 1'b0;
    end else if (n == 5) begin
      return 1'b1;
    end
    return modeHigh[SEL_FIRST + n - 1]; // [RL1]
  endfunction

  function automatic logic capcmp(input int n);
    if (n == 0) begin
      return unitCtrl[UNIT_CAPCMP0];
    end else if (n == 5) begin
      return unitCtrl[UNIT_CAPCMP5];
    end
    return outCtl[(n - 1) * OUT_FIELD + OUT_CAPCMP];
  endfunction

  function automatic logic outBit(input int m, input int k);
    return outCtl[(m - 1) * OUT_FIELD + k];
  endfunction

  function automatic logic isAddr(input logic [31:0] a, input logic [31:0] idx);
    return a == byteAddr(idx);
  endfunction

  // Counters and capture inputs

  ccc_counter counterA (
    .clock    (clock),
    .resetn   (resetn),
    .enable   (unitCtrl[UNIT_EN_A]),
    .count    (countA),
    .running  (runA),
    .stepped  (stepA),
    .overflow (ovfA)
  );

  ccc_counter counterB (
    .clock    (clock),
    .resetn   (resetn),
    .enable   (unitCtrl[UNIT_EN_B]),
    .count    (countB),
    .running  (runB),
    .stepped  (stepB),
    .overflow (ovfB)
  );

  for (genvar g = 0; g < 6; g++) begin : gen_edge
    ccc_edge_detect edgeDetect (
      .clock  (clock),
      .resetn (resetn),
      .pin    (captureInput[g]),
      .select (edgeSel[2 * g +: 2]),
      .hit    (edgeHit[g])
    );
  end

  // Per-channel routing and events

  always_comb begin
    for (int n = 0; n < 6; n++) begin
      chCount[n]   = selB(n) ? countB : countA; // [RL1]
      chOvf[n]     = selB(n) ? ovfB : ovfA;
      chStep[n]    = selB(n) ? stepB : stepA;
      chEn[n]      = selB(n) ? unitCtrl[UNIT_EN_B] : unitCtrl[UNIT_EN_A];
      capHit[n]    = !capcmp(n) && edgeHit[n]; // [RL9]
      cmpHit[n]    = capcmp(n) && chStep[n] && (chCount[n] == valueReg[n]); // [RL10]
      valueRead[n] = readAccept && (haddr == valueAddr(n));
    end
  end

  // Bus slave: zero wait states, address phase latched

  assign accept     = hsel && htrans[1] && hready;
  assign readAccept = accept && !hwrite;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dataWrite <= 1'b0;
      dataAddr  <= 32'h00000000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready) begin
      dataWrite <= accept && hwrite;
      dataAddr  <= haddr;
      hrdata    <= readAccept ? rdValue : 32'h00000000;
    end
  end

  always_comb begin
    rdValue = 32'h00000000;
    if (isAddr(haddr, IDX_CHANNEL_MODE_LOW)) begin
      rdValue = {24'h000000, modeLow}; // [RL4]
    end
    if (isAddr(haddr, IDX_CHANNEL_MODE_HIGH)) begin
      rdValue = {24'h000000, modeHigh}; // [RL4]
    end
    if (isAddr(haddr, IDX_OUTPUT_CTRL_LOW)) begin
      rdValue = {24'h000000, outCtlLow};
    end
    if (isAddr(haddr, IDX_OUTPUT_CTRL_HIGH)) begin
      rdValue = {24'h000000, outCtlHigh};
    end
    if (isAddr(haddr, IDX_TIMER_STATUS)) begin
      rdValue = {24'h000000, runB, runA, ovfFlag}; // [RL14] [RL15]
    end
    if (isAddr(haddr, IDX_UNIT_CTRL)) begin
      rdValue = {24'h000000, unitCtrl};
    end
    if (isAddr(haddr, IDX_IRQ_STATUS)) begin
      rdValue = {26'h0000000, irqStatus};
    end
    if (isAddr(haddr, IDX_IRQ_MASK)) begin
      rdValue = {26'h0000000, irqMask};
    end
    for (int n = 0; n < 6; n++) begin
      if (haddr == valueAddr(n)) begin
        rdValue = {16'h0000, valueReg[n]};
      end
    end
  end

  // Configuration registers; the status register takes no write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      modeLow    <= MODE_RESET;
      modeHigh   <= MODE_RESET;
      outCtlLow  <= OUTCTL_RESET;
      outCtlHigh <= OUTCTL_RESET;
      unitCtrl   <= UNIT_RESET;
      irqMask    <= IRQ_RESET;
    end else if (dataWrite) begin
      if (isAddr(dataAddr, IDX_CHANNEL_MODE_LOW)) begin
        modeLow <= hwdata[7:0]; // [RL4]
      end
      if (isAddr(dataAddr, IDX_CHANNEL_MODE_HIGH)) begin
        modeHigh <= hwdata[7:0]; // [RL4]
      end
      if (isAddr(dataAddr, IDX_OUTPUT_CTRL_LOW)) begin
        outCtlLow <= hwdata[7:0] & OUTCTL_WMASK; // [RL18]
      end
      if (isAddr(dataAddr, IDX_OUTPUT_CTRL_HIGH)) begin
        outCtlHigh <= hwdata[7:0] & OUTCTL_WMASK; // [RL18]
      end
      if (isAddr(dataAddr, IDX_UNIT_CTRL)) begin
        unitCtrl <= hwdata[7:0] & UNIT_WMASK;
      end
      if (isAddr(dataAddr, IDX_IRQ_MASK)) begin
        irqMask <= hwdata[5:0];
      end
    end
  end

  // Value registers: a capture wins over a software write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int n = 0; n < 6; n++) begin
        valueReg[n] <= VALUE_RESET;
      end
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (capHit[n]) begin
          valueReg[n] <= chCount[n]; // [RL9]
        end else if (dataWrite && dataAddr == valueAddr(n)) begin
          valueReg[n] <= hwdata[15:0];
        end
      end
    end
  end

  // Overflows wait in pendOvf until the value register is read
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pendOvf <= 6'h00;
      ovfFlag <= 6'h00;
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (valueRead[n]) begin
          ovfFlag[n] <= pendOvf[n] || chOvf[n]; // [RL13]
          pendOvf[n] <= chOvf[n];
        end else if (chOvf[n]) begin
          pendOvf[n] <= 1'b1; // [RL12]
        end
      end
    end
  end

  // Channel interrupts: sticky, write one to clear, set wins
  assign irqClear = (dataWrite && isAddr(dataAddr, IDX_IRQ_STATUS)) ? hwdata[5:0] : 6'h00;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irqStatus <= IRQ_RESET;
      irq       <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | capHit | cmpHit; // [RL9] [RL10]
      irq       <= |(irqStatus & irqMask);
    end
  end

  // Pulse outputs: active from overflow until compare match
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pwmPhase    <= 4'h0;
      timerOutput <= TIMER_OUT_RESET;
    end else begin
      for (int m = 1; m <= 4; m++) begin
        if (cmpHit[m]) begin
          pwmPhase[m - 1] <= 1'b0; // [RL10]
        end else if (chOvf[m]) begin
          pwmPhase[m - 1] <= 1'b1;
        end
        if (outBit(m, OUT_GATE) && capcmp(m) && chEn[m] && pwmPhase[m - 1]) begin // [RL5] [RL16]
          timerOutput[m - 1] <= outBit(m, OUT_ALV); // [RL6]
        end else begin
          timerOutput[m - 1] <= !outBit(m, OUT_ALV); // [RL5] [RL6]
        end
      end
    end
  end

  a_gate_inactive: assert property (!outCtl[OUT_GATE] |=> timerOutput[0] == !$past(outCtl[OUT_ALV])) // [RL5]
    else $error("gated-off output not at inactive level");
  a_active_level: assert property (outCtl[OUT_GATE] && capcmp(1) && chEn[1] && pwmPhase[0]
      |=> timerOutput[0] == $past(outCtl[OUT_ALV])) // [RL6]
    else $error("active output has wrong polarity");
  a_capture_copy: assert property (capHit[0] |=> valueReg[0] == $past(countA) && irqStatus[0]) // [RL9]
    else $error("capture did not copy counter or raise interrupt");
  a_compare_irq: assert property (cmpHit[1] |=> irqStatus[1] && !pwmPhase[0]) // [RL10]
    else $error("compare match without interrupt");
  a_select_b: assert property (modeHigh[SEL_FIRST] && ovfB && !valueRead[1] |=> pendOvf[1]) // [RL1]
    else $error("channel one not following counter b");
  a_flag_held: assert property (!valueRead[2] |=> $stable(ovfFlag[2])) // [RL13]
    else $error("overflow flag changed without value read");
  a_flag_update: assert property (valueRead[0] && pendOvf[0] |=> ovfFlag[0]) // [RL12]
    else $error("pending overflow not reported after read");
  a_rsvd_zero: assert property ((outCtl & ~{OUTCTL_WMASK, OUTCTL_WMASK}) == 16'h0000) // [RL18]
    else $error("reserved output control bit set");
  a_status_read: assert property (readAccept && isAddr(haddr, IDX_TIMER_STATUS)
      |=> hrdata[7:6] == $past({runB, runA})) // [RL14] [RL15]
    else $error("status read does not show running counters");

  // Routing, output, interrupt and bus checks
  a_enable_off: assert property (!chEn[1] |=> timerOutput[0] == !$past(outCtl[OUT_ALV])) // [RL16]
    else $error("output of stopped counter not inactive");
  a_select_a: assert property (!modeHigh[SEL_FIRST] |-> chCount[1] == countA) // [RL1]
    else $error("channel one not on counter a");
  a_irq_level: assert property (irq == $past(|(irqStatus & irqMask))) // [RL9] [RL10]
    else $error("interrupt output not following masked status");
  a_mask_hold: assert property (irqMask == 6'h00 |=> !irq) // [RL9]
    else $error("interrupt raised with all channels masked");
  a_bus_okay: assert property (hreadyout && !hresp) // [RL4]
    else $error("bus slave not ready or not okay");
endmodule
`default_nettype wire

/* sim/ccc_testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ccc_pkg::*;
;
  localparam logic [31:0] A_ML = 32'hFFFFC810;
  localparam logic [31:0] A_MH = 32'hFFFFC818;
  localparam logic [31:0] A_OL = 32'hFFFFC820;
  localparam logic [31:0] A_OH = 32'hFFFFC828;
  localparam logic [31:0] A_ST = 32'hFFFFC830;
  localparam logic [31:0] A_UC = 32'hFFFFC840;
  localparam logic [31:0] A_IS = 32'hFFFFC848;
  localparam logic [31:0] A_IM = 32'hFFFFC850;
  localparam logic [31:0] VAL0 = 32'hFFFFC880;
  localparam logic [31:0] VAL1 = 32'hFFFFC888;
  localparam logic [31:0] VAL2 = 32'hFFFFC890;

  logic        clock        = 1'b0;
  logic        resetn       = 1'b0;
  logic        hsel         = 1'b0;
  logic [31:0] haddr        = 32'h0;
  logic [1:0]  htrans       = 2'h0;
  logic        hwrite       = 1'b0;
  logic [2:0]  hsize        = 3'h2;
  logic [31:0] hwdata       = 32'h0;
  logic [5:0]  captureInput = 6'h00;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  timerOutput;
  logic        irq;
  int          err_count    = 0;
  int          n_compared   = 0;
  int          cycles       = 0;

  assign hready = hreadyout;

  ccc_channel_unit dut (
    .clock        (clock),
    .resetn       (resetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .captureInput (captureInput),
    .timerOutput  (timerOutput),
    .irq          (irq)
  );

  always #12.5 clock = ~clock;

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      check("run length", 32'h0, 32'h1);
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One single AHB transfer, then an idle cycle so a later read sees the write
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    @(posedge clock);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(what, exp, r);
  endtask

  task automatic test_reset;
    rdc("mode low", A_ML, 32'h00);
    rdc("mode high", A_MH, 32'h00);
    rdc("out ctl low", A_OL, 32'h44);
    rdc("out ctl high", A_OH, 32'h44);
    rdc("status", A_ST, 32'h00);
    check("outputs", 32'h0, {28'h0, timerOutput});
    check("bus okay", 32'h0, {31'h0, hresp});
    $display("test_reset done");
  endtask

  task automatic test_compare;
    logic [31:0] r;
    int          k;
    wr(VAL1, 32'h0080);
    wr(A_IM, 32'h3F);
    wr(A_OL, 32'h4E);
    // Channel 0 in compare mode too: its value 0 matches after the wrap
    wr(A_UC, 32'h05);
    k = 0;
    while (irq !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    check("match delay", 32'h1, {31'h0, k >= 125 && k <= 150});
    rdc("match irq", A_IS, 32'h02);
    rdc("running a", A_ST, 32'h40);
    wr(A_IS, 32'h02);
    k = 0;
    while (timerOutput[0] !== 1'b1 && k < 66000) begin
      @(posedge clock);
      k++;
    end
    check("pwm active", 32'h1, {31'h0, timerOutput[0]});
    rdc("flag before read", A_ST, 32'h40);
    rd(VAL0, r);
    rdc("flag ch0", A_ST, 32'h41);
    rd(VAL1, r);
    rdc("flag ch1", A_ST, 32'h43);
    k = 0;
    while (timerOutput[0] !== 1'b0 && k < 300) begin
      @(posedge clock);
      k++;
    end
    check("pwm inactive", 32'h0, {31'h0, timerOutput[0]});
    rdc("second match", A_IS, 32'h03);
    wr(A_UC, 32'h00);
    tick(10);
    rdc("stopped a", A_ST, 32'h03);
    rd(VAL0, r);
    rd(VAL1, r);
    rdc("flags cleared", A_ST, 32'h00);
    wr(A_IS, 32'h3F);
    wr(A_OL, 32'h44);
    $display("test_compare done");
  endtask

  task automatic test_access;
    wr(A_ML, 32'hFF);
    wr(A_MH, 32'hFF);
    wr(A_OL, 32'hFF);
    wr(A_OH, 32'hFF);
    wr(A_ST, 32'hFF);
    wr(32'hFFFFC900, 32'hFF);
    rdc("mode low rw", A_ML, 32'hFF);
    rdc("mode high rw", A_MH, 32'hFF);
    rdc("reserved low", A_OL, 32'hEE);
    rdc("reserved high", A_OH, 32'hEE);
    rdc("status ro", A_ST, 32'h00);
    rdc("unmapped", 32'hFFFFC900, 32'h00);
    wr(A_ML, 32'h00);
    wr(A_MH, 32'h00);
    wr(A_OL, 32'h44);
    wr(A_OH, 32'h44);
    $display("test_access done");
  endtask

  task automatic test_edges;
    logic [1:0] e;
    for (int c = 0; c < 4; c++) begin
      e = c[1:0];
      wr(A_ML, {28'h0, e, 2'b00});
      wr(A_IS, 32'h3F);
      captureInput[1] <= 1'b1;
      tick(8);
      rdc("rise hit", A_IS, {30'h0, e[0], 1'b0});
      wr(A_IS, 32'h3F);
      captureInput[1] <= 1'b0;
      tick(8);
      rdc("fall hit", A_IS, {30'h0, ~(e[1] ^ e[0]), 1'b0});
    end
    wr(A_IM, 32'h00);
    wr(A_ML, 32'h04);
    wr(A_IS, 32'h3F);
    captureInput[1] <= 1'b1;
    tick(8);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(A_IM, 32'h02);
    tick(2);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(A_IS, 32'h02);
    tick(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    captureInput[1] <= 1'b0;
    wr(A_IM, 32'h3F);
    $display("test_edges done");
  endtask

  task automatic test_capture;
    logic [31:0] v1;
    logic [31:0] v2;
    wr(A_ML, 32'h14);
    wr(A_IS, 32'h3F);
    wr(A_UC, 32'h01);
    tick(20);
    captureInput[1] <= 1'b1;
    tick(20);
    captureInput[2] <= 1'b1;
    tick(8);
    rd(VAL1, v1);
    rd(VAL2, v2);
    check("capture spacing", 32'd20, v2 - v1);
    check("counter a capture", 32'h1, {31'h0, v1 != 32'h0});
    rdc("capture irq", A_IS, 32'h06);
    // Channel 2 moves to the second counter, which never ran
    wr(A_MH, 32'h20);
    captureInput[2] <= 1'b0;
    tick(4);
    captureInput[2] <= 1'b1;
    tick(8);
    rdc("counter b capture", VAL2, 32'h0000);
    wr(A_UC, 32'h00);
    captureInput <= 6'h00;
    tick(8);
    wr(A_ML, 32'h00);
    wr(A_MH, 32'h00);
    wr(A_IS, 32'h3F);
    $display("test_capture done");
  endtask

  task automatic test_levels;
    wr(A_OL, 32'h00);
    wr(A_OH, 32'h00);
    tick(2);
    check("inactive low level", 32'hF, {28'h0, timerOutput});
    wr(A_OL, 32'h88);
    tick(2);
    check("stopped gate on", 32'h3, {30'h0, timerOutput[1:0]});
    wr(A_OL, 32'h44);
    wr(A_OH, 32'h44);
    tick(2);
    check("inactive high level", 32'h0, {28'h0, timerOutput});
    $display("test_levels done");
  endtask

  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    test_reset();
    test_compare();
    test_access();
    test_edges();
    test_capture();
    test_levels();
    stop_test();
  end
endmodule
`default_nettype wire
